// [core/ffrc_core.sv]
// function/lock and read-parameter registers of a serial flash,
// written and read by serial commands on the link clock sck
// assumes program/erase status and suspend/resume pulses come
// from array control on mclk, and the quad bit from status logic
`timescale 1ns/100ps
`include "ffrc_regs.svh"

module ffrc_core #(
    parameter logic DEDICATED_RST_DISABLED = 1'b0
) (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     sck,
    input  wire logic                     cs_n,
    input  wire logic                     si,
    output logic                          so,
    output logic                          so_oe,
    input  wire logic                     program_busy,
    input  wire logic                     erase_busy,
    input  wire logic                     suspend_cmd,
    input  wire logic                     resume_cmd,
    input  wire logic                     quad_lines_enable,
    input  wire logic                     qpi_mode,
    input  wire ffrc_pkg::ffrc_read_kind_t read_kind,
    output logic [7:0]                    function_config_lock,
    output logic [7:0]                    read_parameters,
    output logic [7:0]                    read_params_persistent,
    output logic                          dedicated_reset_enable,
    output logic                          shared_pin_hold,
    output logic                          shared_pin_reset,
    output logic                          data_line_2_enable,
    output logic                          data_line_3_enable,
    output logic                          protect_region_top_bottom,
    output logic [3:0]                    info_row_lock,
    output logic                          program_suspended_flag,
    output logic                          erase_suspended_flag,
    output logic [3:0]                    dummy_cycles,
    output logic                          wrap_at_burst,
    output logic [6:0]                    burst_bytes
);

    // dummy count for the current read
    function automatic logic [3:0] dummy_count(
        input ffrc_pkg::ffrc_read_kind_t kind,
        input logic                      qpi,
        input logic [3:0]                field
    );
        logic [3:0] cnt;
        cnt = field;
        if (field == 4'h0) begin
            if (kind == ffrc_pkg::FFRC_RK_DUAL_IO) begin
                cnt = `FFRC_DUMMY_DUAL_IO;
            end else if (kind == ffrc_pkg::FFRC_RK_QUAD_IO) begin
                cnt = `FFRC_DUMMY_QUAD_IO;
            end else if (qpi) begin
                cnt = `FFRC_DUMMY_FAST_QPI;
            end else begin
                cnt = `FFRC_DUMMY_FAST_SPI;
            end
        end
        return cnt;
    endfunction

    // wrapped burst length in bytes
    function automatic logic [6:0] burst_len(
        input logic [1:0] code
    );
        return `FFRC_BURST_MIN << code;
    endfunction

    // link side
    logic [7:0] snap_func_q, snap_func_d;
    logic [7:0] snap_rp_q,   snap_rp_d;
    logic [7:0] cmd_op;
    logic [7:0] cmd_data;
    logic       cmd_tgl;

    ffrc_link u_link (
        .sck       (sck),
        .cs_n      (cs_n),
        .reset     (reset),
        .si        (si),
        .snap_func (snap_func_q),
        .snap_rp   (snap_rp_q),
        .so        (so),
        .so_oe     (so_oe),
        .cmd_op    (cmd_op),
        .cmd_data  (cmd_data),
        .cmd_tgl   (cmd_tgl)
    );

    // synchronisers: frame level and command toggle
    logic       cs_meta_q, cs_sync_q;
    logic       tgl_meta_q, tgl_sync_q, tgl_seen_q;
    logic       cmd_stb;
    logic       frame_idle;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cs_meta_q  <= 1'b1;
            cs_sync_q  <= 1'b1;
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
            tgl_seen_q <= 1'b0;
        end else begin
            cs_meta_q  <= cs_n;
            cs_sync_q  <= cs_meta_q;
            tgl_meta_q <= cmd_tgl;
            tgl_sync_q <= tgl_meta_q;
            tgl_seen_q <= tgl_sync_q;
        end
    end

    assign cmd_stb    = tgl_sync_q ^ tgl_seen_q;
    assign frame_idle = cs_sync_q;

    // configuration state
    ffrc_pkg::ffrc_state_t state_q, state_d;
    logic [7:0] fn_otp_q, fn_otp_d;
    logic       prog_susp_q,  prog_susp_d;
    logic       erase_susp_q, erase_susp_d;
    logic [7:0] rp_nv_q,  rp_nv_d;
    logic [7:0] rp_vol_q, rp_vol_d;
    logic [7:0] fn_view;
    logic       take;

    // function register as read back
    always_comb begin
        fn_view = fn_otp_q & `FFRC_FN_OTP_MASK;
        fn_view[`FFRC_FN_PROG_SUSP]  = prog_susp_q;
        fn_view[`FFRC_FN_ERASE_SUSP] = erase_susp_q;
    end

    always_comb begin
        state_d  = state_q;
        fn_otp_d = fn_otp_q;
        prog_susp_d  = prog_susp_q;
        erase_susp_d = erase_susp_q;
        rp_nv_d  = rp_nv_q;
        rp_vol_d = rp_vol_q;
        take     = 1'b0;
        unique case (state_q)
            ffrc_pkg::FFRC_ST_BOOT: begin
                rp_vol_d = rp_nv_q;
                state_d  = ffrc_pkg::FFRC_ST_RUN;
            end
            ffrc_pkg::FFRC_ST_RUN: begin
                take = cmd_stb;
            end
            default: begin
                state_d = ffrc_pkg::FFRC_ST_BOOT;
            end
        endcase
        if (take) begin
            unique case (cmd_op)
                `FFRC_OP_WR_FUNC: begin
                    // ones only ever added; zeros ignored
                    fn_otp_d = fn_otp_q | (cmd_data & `FFRC_FN_OTP_MASK);
                end
                `FFRC_OP_SET_RP_NV: begin
                    rp_nv_d = cmd_data;
                end
                `FFRC_OP_SET_RP_V0,
                `FFRC_OP_SET_RP_V1: begin
                    rp_vol_d = cmd_data;
                end
                default: begin
                    rp_vol_d = rp_vol_q;
                end
            endcase
        end
        // resume clears, a suspend in the same cycle wins
        if (resume_cmd && prog_susp_q) begin
            prog_susp_d = 1'b0;
        end
        if (suspend_cmd && program_busy) begin
            prog_susp_d = 1'b1;
        end
        if (resume_cmd && erase_susp_q) begin
            erase_susp_d = 1'b0;
        end
        if (suspend_cmd && erase_busy) begin
            erase_susp_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q  <= ffrc_pkg::FFRC_ST_BOOT;
            fn_otp_q <= `FFRC_FN_RESET | {7'h00, DEDICATED_RST_DISABLED};
            prog_susp_q  <= 1'b0;
            erase_susp_q <= 1'b0;
            rp_nv_q  <= `FFRC_RP_RESET;
            rp_vol_q <= `FFRC_RP_RESET;
        end else begin
            state_q  <= state_d;
            fn_otp_q <= fn_otp_d;
            prog_susp_q  <= prog_susp_d;
            erase_susp_q <= erase_susp_d;
            rp_nv_q  <= rp_nv_d;
            rp_vol_q <= rp_vol_d;
        end
    end

    // snapshot for the link, frozen while a frame runs
    always_comb begin
        snap_func_d = snap_func_q;
        snap_rp_d   = snap_rp_q;
        if (frame_idle) begin
            snap_func_d = fn_view;
            snap_rp_d   = rp_vol_q;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            snap_func_q <= 8'h00;
            snap_rp_q   <= 8'h00;
        end else begin
            snap_func_q <= snap_func_d;
            snap_rp_q   <= snap_rp_d;
        end
    end

    // decoded outputs
    logic       data3;
    logic       rst_role;
    logic [7:0] func_out_d, func_out_q;
    logic [7:0] rp_out_d,   rp_out_q;
    logic [7:0] rp_nv_out_q;
    logic       ded_rst_d,  ded_rst_q;
    logic       hold_d,     hold_q;
    logic       rstp_d,     rstp_q;
    logic       dl2_d,      dl2_q;
    logic       dl3_d,      dl3_q;
    logic [3:0] dummy_d,    dummy_q;
    logic       wrap_d,     wrap_q;
    logic [6:0] burst_d,    burst_q;

    always_comb begin
        data3     = quad_lines_enable | qpi_mode;
        // reset role only when the dedicated pin is given up
        rst_role  = fn_otp_q[`FFRC_FN_RST_DIS] & rp_vol_q[`FFRC_RP_ROLE];
        ded_rst_d = ~fn_otp_q[`FFRC_FN_RST_DIS];
        rstp_d    = ~data3 & rst_role;
        hold_d    = ~data3 & ~rst_role;
        dl2_d     = data3;
        dl3_d     = data3;
        func_out_d = fn_view;
        rp_out_d   = rp_vol_q;
        dummy_d = dummy_count(read_kind, qpi_mode,
                              rp_vol_q[`FFRC_RP_DUMMY_MSB:`FFRC_RP_DUMMY_LSB]);
        wrap_d  = rp_vol_q[`FFRC_RP_WRAP];
        // array-end wrap reports no burst length
        burst_d = wrap_d ? burst_len(rp_vol_q[`FFRC_RP_BL_MSB:`FFRC_RP_BL_LSB]) : 7'h00;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            func_out_q  <= 8'h00;
            rp_out_q    <= 8'h00;
            rp_nv_out_q <= 8'h00;
            ded_rst_q   <= 1'b0;
            hold_q      <= 1'b0;
            rstp_q      <= 1'b0;
            dl2_q       <= 1'b0;
            dl3_q       <= 1'b0;
            dummy_q     <= 4'h0;
            wrap_q      <= 1'b0;
            burst_q     <= 7'h00;
        end else begin
            func_out_q  <= func_out_d;
            rp_out_q    <= rp_out_d;
            rp_nv_out_q <= rp_nv_q;
            ded_rst_q   <= ded_rst_d;
            hold_q      <= hold_d;
            rstp_q      <= rstp_d;
            dl2_q       <= dl2_d;
            dl3_q       <= dl3_d;
            dummy_q     <= dummy_d;
            wrap_q      <= wrap_d;
            burst_q     <= burst_d;
        end
    end

    assign function_config_lock      = func_out_q;
    assign read_parameters           = rp_out_q;
    assign read_params_persistent    = rp_nv_out_q;
    assign dedicated_reset_enable    = ded_rst_q;
    assign shared_pin_hold           = hold_q;
    assign shared_pin_reset          = rstp_q;
    assign data_line_2_enable        = dl2_q;
    assign data_line_3_enable        = dl3_q;
    assign protect_region_top_bottom = func_out_q[`FFRC_FN_BOTTOM];
    assign info_row_lock             = func_out_q[`FFRC_FN_IRL_MSB:`FFRC_FN_IRL_LSB];
    assign program_suspended_flag    = func_out_q[`FFRC_FN_PROG_SUSP];
    assign erase_suspended_flag      = func_out_q[`FFRC_FN_ERASE_SUSP];
    assign dummy_cycles              = dummy_q;
    assign wrap_at_burst             = wrap_q;
    assign burst_bytes               = burst_q;

endmodule // ffrc_core

// [core/ffrc_link.sv]
// serial-clock side of the register block: takes opcode and data
// byte, hands writes over by toggle, shifts register reads out
// assumes snap_func/snap_rp stay still while cs_n is low
`timescale 1ns/100ps
`include "ffrc_regs.svh"

module ffrc_link (
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       reset,
    input  wire logic       si,
    input  wire logic [7:0] snap_func,
    input  wire logic [7:0] snap_rp,
    output logic            so,
    output logic            so_oe,
    output logic [7:0]      cmd_op,
    output logic [7:0]      cmd_data,
    output logic            cmd_tgl
);

    logic       frame_rst;
    logic [4:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q,   shift_d;
    logic [7:0] op_q,      op_d;
    logic       rd_q,      rd_d;
    logic [7:0] cop_q,     cop_d;
    logic [7:0] cdat_q,    cdat_d;
    logic       tgl_q,     tgl_d;
    logic [7:0] tx_q,      tx_d;
    logic [7:0] rx_byte;

    // frame end clears the framing state
    assign frame_rst = cs_n | reset;
    assign rx_byte   = {shift_q[6:0], si};

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        if (bit_cnt_q != `FFRC_BIT_CNT_MAX) begin
            bit_cnt_d = bit_cnt_q + 5'h01;
        end
        shift_d = rx_byte;
        op_d    = op_q;
        rd_d    = rd_q;
        cop_d   = cop_q;
        cdat_d  = cdat_q;
        tgl_d   = tgl_q;
        if (bit_cnt_q == `FFRC_OP_LAST_BIT) begin
            op_d = rx_byte;
            rd_d = (rx_byte == `FFRC_OP_RD_FUNC) ||
                   (rx_byte == `FFRC_OP_RD_RP);
        end
        if (bit_cnt_q == `FFRC_DATA_LAST_BIT && !rd_q) begin
            cop_d  = op_q;
            cdat_d = rx_byte;
            tgl_d  = ~tgl_q;
        end
    end

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 8'h00;
            op_q      <= 8'h00;
            rd_q      <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            op_q      <= op_d;
            rd_q      <= rd_d;
        end
    end

    // handed-over command survives the frame end
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            cop_q  <= 8'h00;
            cdat_q <= 8'h00;
            tgl_q  <= 1'b0;
        end else begin
            cop_q  <= cop_d;
            cdat_q <= cdat_d;
            tgl_q  <= tgl_d;
        end
    end

    // read data: load on falling edge after opcode, then rotate
    always_comb begin
        tx_d = tx_q;
        if (rd_q && bit_cnt_q == `FFRC_RD_FIRST_BIT) begin
            tx_d = (op_q == `FFRC_OP_RD_FUNC) ? snap_func : snap_rp;
        end else if (rd_q) begin
            tx_d = {tx_q[6:0], tx_q[7]};
        end
    end

    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_q <= 8'h00;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign so       = tx_q[7];
    assign so_oe    = ~cs_n & rd_q;
    assign cmd_op   = cop_q;
    assign cmd_data = cdat_q;
    assign cmd_tgl  = tgl_q;

endmodule // ffrc_link

// [core/ffrc_pkg.sv]
// types of the flash function/read-parameter block
// no dependencies
package ffrc_pkg;

    typedef enum logic [2:0] {
        FFRC_RK_FAST     = 3'h0,
        FFRC_RK_DUAL_OUT = 3'h1,
        FFRC_RK_QUAD_OUT = 3'h2,
        FFRC_RK_DUAL_IO  = 3'h3,
        FFRC_RK_QUAD_IO  = 3'h4
    } ffrc_read_kind_t;

    typedef enum logic [1:0] {
        FFRC_ST_BOOT = 2'b01,
        FFRC_ST_RUN  = 2'b10
    } ffrc_state_t;

endpackage

// [core/ffrc_regs.svh]
// register layout, opcodes and field constants of the flash
// function/read-parameter block; definitions only
`ifndef FFRC_REGS_SVH
`define FFRC_REGS_SVH

// serial opcodes
`define FFRC_OP_WR_FUNC    8'h42
`define FFRC_OP_RD_FUNC    8'h48
`define FFRC_OP_RD_RP      8'h61
`define FFRC_OP_SET_RP_NV  8'h65
`define FFRC_OP_SET_RP_V0  8'hc0
`define FFRC_OP_SET_RP_V1  8'h63

// function register fields
`define FFRC_FN_RST_DIS    0
`define FFRC_FN_BOTTOM     1
`define FFRC_FN_PROG_SUSP  2
`define FFRC_FN_ERASE_SUSP 3
`define FFRC_FN_IRL_LSB    4
`define FFRC_FN_IRL_MSB    7
`define FFRC_FN_OTP_MASK   8'hf3
`define FFRC_FN_RESET      8'h00

// read-parameter register fields
`define FFRC_RP_ROLE       7
`define FFRC_RP_DUMMY_MSB  6
`define FFRC_RP_DUMMY_LSB  3
`define FFRC_RP_WRAP       2
`define FFRC_RP_BL_MSB     1
`define FFRC_RP_BL_LSB     0
`define FFRC_RP_RESET      8'h00

// default dummy counts when the field is zero
`define FFRC_DUMMY_FAST_SPI 4'h8
`define FFRC_DUMMY_FAST_QPI 4'h6
`define FFRC_DUMMY_DUAL_IO  4'h4
`define FFRC_DUMMY_QUAD_IO  4'h6

// smallest wrapped burst in bytes
`define FFRC_BURST_MIN     7'h08

// link framing in serial clocks
`define FFRC_OP_LAST_BIT   5'h07
`define FFRC_RD_FIRST_BIT  5'h08
`define FFRC_DATA_LAST_BIT 5'h0f
`define FFRC_BIT_CNT_MAX   5'h10

`endif

// [dv/ffrc_core_asserts.sv]
// concurrent checks on the mclk-side ports of ffrc_core
// assumes every watched output is registered on mclk
`timescale 1ns/100ps
`include "ffrc_regs.svh"

module ffrc_core_asserts (
    input wire logic                      mclk,
    input wire logic                      reset,
    input wire logic                      program_busy,
    input wire logic                      erase_busy,
    input wire logic                      suspend_cmd,
    input wire logic                      resume_cmd,
    input wire logic                      quad_lines_enable,
    input wire logic                      qpi_mode,
    input wire ffrc_pkg::ffrc_read_kind_t read_kind,
    input wire logic [7:0]                function_config_lock,
    input wire logic [7:0]                read_parameters,
    input wire logic                      dedicated_reset_enable,
    input wire logic                      shared_pin_hold,
    input wire logic                      shared_pin_reset,
    input wire logic                      data_line_3_enable,
    input wire logic                      program_suspended_flag,
    input wire logic                      erase_suspended_flag,
    input wire logic [3:0]                dummy_cycles,
    input wire logic [6:0]                burst_bytes
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    otp_sticky_a: assert property (
        ((~function_config_lock) & $past(function_config_lock) & `FFRC_FN_OTP_MASK) == 8'h00)
        else $error("one-time bit went back to zero");
    reset_pin_a: assert property (
        $stable(function_config_lock)[*3] |-> dedicated_reset_enable == !function_config_lock[0])
        else $error("dedicated reset enable disagrees with bit 0");
    prog_susp_set_a: assert property (
        program_busy && suspend_cmd ##1 !resume_cmd |-> ##1 program_suspended_flag)
        else $error("program suspend flag not set");
    erase_susp_set_a: assert property (
        erase_busy && suspend_cmd ##1 !resume_cmd |-> ##1 erase_suspended_flag)
        else $error("erase suspend flag not set");
    prog_susp_clear_a: assert property (
        resume_cmd && !suspend_cmd && program_suspended_flag && !erase_suspended_flag ##1 !suspend_cmd
        |-> ##1 !program_suspended_flag)
        else $error("program suspend flag not cleared");
    quad_data_a: assert property (
        (quad_lines_enable || qpi_mode)[*3] |-> data_line_3_enable && !shared_pin_hold && !shared_pin_reset)
        else $error("shared pin not data in quad mode");
    hold_forced_a: assert property (
        (!quad_lines_enable && !qpi_mode && dedicated_reset_enable)[*3] |-> shared_pin_hold && !shared_pin_reset)
        else $error("hold role not forced");
    role_select_a: assert property (
        (!quad_lines_enable && !qpi_mode && !dedicated_reset_enable && $stable(read_parameters))[*3]
        |-> shared_pin_reset == read_parameters[7] && shared_pin_hold == !read_parameters[7])
        else $error("shared pin role disagrees with bit 7");
    dummy_field_a: assert property (
        (read_parameters[6:3] != 4'h0 && $stable(read_parameters))[*2] |-> dummy_cycles == read_parameters[6:3])
        else $error("dummy count not taken from field");
    dummy_dflt_a: assert property ((read_parameters[6:3] == 4'h0 && $stable(read_parameters)
        && $stable(read_kind) && read_kind == ffrc_pkg::FFRC_RK_DUAL_IO)[*2] |-> dummy_cycles == `FFRC_DUMMY_DUAL_IO)
        else $error("dual io default dummy count wrong");
    burst_len_a: assert property ($stable(read_parameters)[*2] |-> burst_bytes ==
        (read_parameters[2] ? (`FFRC_BURST_MIN << read_parameters[1:0]) : 7'h00))
        else $error("burst length decode wrong");
endmodule // ffrc_core_asserts

bind ffrc_core ffrc_core_asserts ffrc_core_asserts_inst (.mclk, .reset, .program_busy, .erase_busy, .suspend_cmd,
    .resume_cmd, .quad_lines_enable, .qpi_mode, .read_kind, .function_config_lock, .read_parameters,
    .dedicated_reset_enable, .shared_pin_hold, .shared_pin_reset, .data_line_3_enable, .program_suspended_flag,
    .erase_suspended_flag, .dummy_cycles, .burst_bytes);

// [dv/ffrc_host_model.sv]
// serial host model driving the register link of ffrc_core
// assumes mode 0 framing: sck idle low, data changed on falling edge
`timescale 1ns/100ps

module ffrc_host_model (
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    input wire logic so,
    input wire logic so_oe
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // one frame: opcode then data byte, msb first; 8 mhz sck
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {op, dat};
        rd = 8'h00;
        #3 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            si = sh[i];
            #62.5 sck = 1'b1;
            if (i < 8)
                rd = {rd[6:0], so_oe ? so : 1'bx};
            #62.5 sck = 1'b0;
        end
        si = ~si;
        #62.5 cs_n = 1'b1;
        #250;
    endtask
endmodule // ffrc_host_model

// [dv/flash_function_read_config_tb_top.sv]
// self-checking bench of ffrc_core against a register model
// assumes ffrc_host_model plays the serial host on sck
`timescale 1ns/100ps

module flash_function_read_config_tb_top;
    logic                      mclk, reset, program_busy, erase_busy, suspend_cmd, resume_cmd, quad_lines_enable;
    logic                      qpi_mode, sck, cs_n, si, so, so_oe, dedicated_reset_enable, shared_pin_hold;
    logic                      shared_pin_reset, data_line_2_enable, data_line_3_enable, protect_region_top_bottom;
    logic                      wrap_at_burst, program_suspended_flag, erase_suspended_flag;
    logic [3:0]                info_row_lock, dummy_cycles;
    logic [6:0]                burst_bytes;
    logic [7:0]                function_config_lock, read_parameters, read_params_persistent, fn_m, rpw_m, rpp_m, rd, d;
    ffrc_pkg::ffrc_read_kind_t read_kind;
    int                        n_errors, checks_done, cycles, seed;

    ffrc_core ffrc_core_inst (.mclk, .reset, .sck, .cs_n, .si, .so, .so_oe, .program_busy, .erase_busy, .suspend_cmd,
        .resume_cmd, .quad_lines_enable, .qpi_mode, .read_kind, .function_config_lock, .read_parameters,
        .read_params_persistent, .dedicated_reset_enable, .shared_pin_hold, .shared_pin_reset, .data_line_2_enable,
        .data_line_3_enable, .protect_region_top_bottom, .info_row_lock, .program_suspended_flag,
        .erase_suspended_flag, .dummy_cycles, .wrap_at_burst, .burst_bytes);
    ffrc_host_model ffrc_host_model_inst (.sck, .cs_n, .si, .so, .so_oe);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
        ffrc_host_model_inst.xfer(op, dat, rd);
        cyc(2);
    endtask

    task automatic pulse(input logic res);
        @(posedge mclk);
        suspend_cmd <= !res;
        resume_cmd  <= res;
        @(posedge mclk);
        suspend_cmd <= 1'b0;
        resume_cmd  <= 1'b0;
        cyc(3);
    endtask

    function automatic logic [7:0] exp_dummy(input int kind, input logic qpi);
        if (rpw_m[6:3] != 4'h0)
            return {4'h0, rpw_m[6:3]};
        if (kind == 3)
            return 8'h04;
        if (kind == 4)
            return 8'h06;
        return qpi ? 8'h06 : 8'h08;
    endfunction

    // decoded outputs of the working copy, every read kind in both modes
    task automatic chk_rp;
        chk({1'b0, burst_bytes}, rpw_m[2] ? (8'h08 << rpw_m[1:0]) : 8'h00);
        chk({7'h00, wrap_at_burst}, {7'h00, rpw_m[2]});
        chk({6'h00, shared_pin_hold, shared_pin_reset}, (fn_m[0] && rpw_m[7]) ? 8'h01 : 8'h02);
        for (int k = 0; k < 10; k++) begin
            @(posedge mclk);
            read_kind <= ffrc_pkg::ffrc_read_kind_t'(k / 2);
            qpi_mode  <= k[0];
            cyc(3);
            chk({4'h0, dummy_cycles}, exp_dummy(k / 2, k[0]));
        end
        @(posedge mclk);
        qpi_mode <= 1'b0;
        cyc(3);
    endtask

    initial begin
        seed = 28094;
        {reset, program_busy, erase_busy, suspend_cmd, resume_cmd, quad_lines_enable, qpi_mode} = 7'h40;
        read_kind = ffrc_pkg::FFRC_RK_FAST;
        fn_m = 8'h00;
        rpw_m = 8'h00;
        rpp_m = 8'h00;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        cyc(4);
        chk(function_config_lock, fn_m);
        chk(read_parameters, 8'h00);
        for (int p = 0; p < 2; p++) begin
            d = $random(seed);
            d = p ? 8'hff : (d & 8'hf2);
            fn_m = fn_m | (d & 8'hf3);
            cmd(8'h42, d);
            cmd(8'h42, 8'h00);
            cmd(8'h48, 8'h00);
            chk(rd, fn_m);
            chk(function_config_lock, fn_m);
            chk({info_row_lock, 2'b00, protect_region_top_bottom, dedicated_reset_enable},
                {fn_m[7:4], 2'b00, fn_m[1], ~fn_m[0]});
            for (int i = 0; i < 6; i++) begin
                d = $random(seed);
                if (i < 4)
                    d[2:0] = {1'b1, i[1:0]};
                if (i == 1)
                    d[6:3] = 4'h0;
                if (i == 2)
                    d[7] = 1'b1;
                if (i == 4)
                    rpp_m = d;
                else
                    rpw_m = d;
                cmd((i == 4) ? 8'h65 : (i[0] ? 8'h63 : 8'hc0), d);
                cmd(8'h61, 8'h00);
                chk(rd, rpw_m);
                chk(read_params_persistent, rpp_m);
                chk_rp();
            end
        end
        rpw_m = 8'h80;
        cmd(8'hc0, rpw_m);
        for (int q = 1; q < 4; q++) begin
            @(posedge mclk);
            {quad_lines_enable, qpi_mode} <= q[1:0];
            cyc(3);
            chk({4'h0, data_line_2_enable, data_line_3_enable, shared_pin_hold, shared_pin_reset}, 8'h0c);
        end
        cmd(8'h5a, 8'hff);
        chk(function_config_lock, fn_m);
        chk(read_parameters, rpw_m);
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            program_busy <= !s[0];
            erase_busy   <= s[0];
            pulse(1'b0);
            chk({6'h00, erase_suspended_flag, program_suspended_flag}, s ? 8'h02 : 8'h01);
            chk(function_config_lock, fn_m | (s ? 8'h08 : 8'h04));
            pulse(1'b1);
            chk({6'h00, erase_suspended_flag, program_suspended_flag}, 8'h00);
        end
        pulse(1'b0);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        cyc(4);
        chk(function_config_lock, 8'h00);
        chk(read_parameters, 8'h00);
        finish_test();
    end
endmodule // flash_function_read_config_tb_top
